// ==== rtl/rcr_reset_cause.v ====
// Purpose: reset cause recording and reset source enables
// Assumes: reset controller reports cause of each system reset on reset_cause
// Notes:   enables written by software; flags latched per reset
//
// Overview of operation
// RQ1: register decoded at address 0xEF, register page 0x00 only.
// RQ2: bit 7 reads zero; writes to it are ignored.
// RQ3: bit 6 set when flash access error caused last reset; read-only.
// RQ4: writing one to bit 5 enables comparator low output as reset source.
// RQ5: bit 5 reads one only if comparator caused last reset.
// RQ6: writing one to bit 4 forces an immediate full system reset.
// RQ7: bit 4 reads one only after a software forced reset.
// RQ8: bit 3 set when watchdog overflow caused last reset; read-only.
// RQ9: writing one to bit 2 enables clock loss detector as reset source.
// RQ10: bit 2 reads one only if clock loss timeout caused last reset.
// RQ11: writing one to bit 1 enables supply monitor as reset source.
// RQ12: software enables supply monitor only after it has stabilized.
// RQ13: bit 1 reads one after any power-on or supply monitor reset.
// RQ14: while power-on flag is one, other flags are undefined.
// RQ15: bit 0 set when external reset pin caused last reset.
// RQ16: writing zero to bit 2 disables detector; internal resets leave pin undriven.
// RQ17: after any reset, watchdog enabled and clocked at system clock over twelve.
// RQ18: each reset latches only its own cause flag, clearing the others.
// RQ19: software writes whole values, never read-modify-write.
`timescale 1ns/1ns
`include "rcr_defs.vh"

module rcr_reset_cause #(
	// divider width and watchdog clock division
	parameter             DIV_W    = 4,
	parameter [DIV_W-1:0] WDOG_DIV = `RCR_WDOG_DIV
) (
	// clock and reset
	input  wire       clk_sys,
	input  wire       rst_n,
	// reset cause reported by reset controller, valid at rst_n release
	input  wire [2:0] reset_cause,
	// special function register bus
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_page,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output wire [7:0] sfr_rdata,
	output wire       sfr_hit,
	// reset sources
	input  wire       cmp_out,
	input  wire       clock_missing,
	input  wire       supply_low,
	input  wire       watchdog_overflow,
	input  wire       flash_fault,
	// reset requests and controls
	output reg        sys_reset_req,
	output wire       pin_reset_oe,
	output wire       clock_loss_detector_en,
	output wire       watchdog_function_en,
	output reg        watchdog_tick
);

	// =====================================================
	// address decode
	// register select on address and page
	function sel_match;
		input [7:0] addr;
		input [7:0] page;
		begin
			sel_match = (addr == `RCR_ADDR) && (page == `RCR_PAGE);
		end
	endfunction

	wire       hit_w;
	wire       wr_w;
	wire       rd_w;
	assign hit_w   = sel_match(sfr_addr, sfr_page); // RQ1
	assign sfr_hit = hit_w;
	assign wr_w    = hit_w && sfr_wr;
	assign rd_w    = hit_w && sfr_rd;

	// =====================================================
	// state
	reg        first_reg;
	reg  [6:0] flag_reg;
	reg        cmp_en_reg;
	reg        clk_en_reg;
	reg        sup_en_reg;
	reg        soft_reg;
	reg  [DIV_W-1:0] div_reg;
	reg  [DIV_W-1:0] div_next;
	reg              tick_next;
	reg  [6:0]       flag_next;
	reg  [7:0]       rdata_reg;
	reg  [7:0]       rdata_next;

	// one-hot flag image of a reported cause
	function [6:0] cause_flags;
		input [2:0] c;
		begin
			cause_flags = 7'h00;
			case (c)
				`RCR_CAUSE_POWER:  cause_flags[`RCR_BIT_SUPPLY] = 1'b1; // RQ13
				`RCR_CAUSE_SUPPLY: cause_flags[`RCR_BIT_SUPPLY] = 1'b1; // RQ13
				`RCR_CAUSE_PIN:    cause_flags[`RCR_BIT_PIN]    = 1'b1; // RQ15
				`RCR_CAUSE_CLK:    cause_flags[`RCR_BIT_CLK]    = 1'b1; // RQ10
				`RCR_CAUSE_CMP:    cause_flags[`RCR_BIT_CMP]    = 1'b1; // RQ5
				`RCR_CAUSE_WDOG:   cause_flags[`RCR_BIT_WDOG]   = 1'b1; // RQ8
				`RCR_CAUSE_SOFT:   cause_flags[`RCR_BIT_SOFT]   = 1'b1; // RQ7
				`RCR_CAUSE_FLASH:  cause_flags[`RCR_BIT_FLASH]  = 1'b1; // RQ3
				default:           cause_flags = 7'h00;
			endcase
		end
	endfunction

	always @* begin
		flag_next = flag_reg;
		if (first_reg) begin
			flag_next = cause_flags(reset_cause); // RQ18
		end
	end

	// =====================================================
	// register process
	// marks the first edge after reset release
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			first_reg <= `RCR_RST_FIRST;
		end else begin
			first_reg <= 1'b0;
		end
	end

	// cause flags, loaded once per reset
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			flag_reg <= `RCR_RST_FLAGS; // RQ18
		end else begin
			flag_reg <= flag_next;
		end
	end

	// source enables, full value on every write
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			cmp_en_reg <= `RCR_RST_BIT;
			clk_en_reg <= `RCR_RST_BIT;
			sup_en_reg <= `RCR_RST_BIT;
		end else if (wr_w) begin
			cmp_en_reg <= sfr_wdata[`RCR_BIT_CMP];    // RQ4
			clk_en_reg <= sfr_wdata[`RCR_BIT_CLK];    // RQ9 RQ16
			sup_en_reg <= sfr_wdata[`RCR_BIT_SUPPLY]; // RQ11
		end
	end

	// software force, one cycle, never read back
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			soft_reg <= `RCR_RST_BIT;
		end else begin
			soft_reg <= wr_w && sfr_wdata[`RCR_BIT_SOFT]; // RQ6
		end
	end

	// =====================================================
	// reset request
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= soft_reg                                  // RQ6
				| (cmp_en_reg & ~cmp_out)                          // RQ4
				| (clk_en_reg & clock_missing)                     // RQ9
				| (sup_en_reg & supply_low)                        // RQ11
				| watchdog_overflow | flash_fault;
		end
	end

	assign pin_reset_oe           = 1'b0; // RQ16
	assign clock_loss_detector_en = clk_en_reg;

	// =====================================================
	// watchdog clock divider
	localparam [DIV_W-1:0] DIV_ONE  = {{(DIV_W-1){1'b0}}, 1'b1};
	localparam [DIV_W-1:0] DIV_ZERO = {DIV_W{1'b0}};

	// last count of one divide period
	function div_last;
		input [DIV_W-1:0] count;
		begin
			div_last = (count == WDOG_DIV - DIV_ONE);
		end
	endfunction

	assign watchdog_function_en = 1'b1; // RQ17

	always @* begin
		tick_next = div_last(div_reg); // RQ17
		div_next  = div_reg + DIV_ONE;
		if (div_last(div_reg)) begin
			div_next = DIV_ZERO;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			div_reg       <= DIV_ZERO;
			watchdog_tick <= `RCR_RST_BIT;
		end else begin
			div_reg       <= div_next;
			watchdog_tick <= tick_next;
		end
	end

	// =====================================================
	// read data
	// bit 7 fixed zero, idle zero unless selected for read
	always @* begin
		rdata_next = `RCR_RST_DATA;
		if (rd_w) begin
			rdata_next = {1'b0, flag_reg}; // RQ2 RQ14
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_reg <= `RCR_RST_DATA;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign sfr_rdata = rdata_reg;

endmodule // rcr_reset_cause

// ==== rtl/rcr_defs.vh ====
// Purpose: constants of the reset cause and enable register
// Assumes: special function register bus with 8-bit data
// Notes:   bit positions and address decode values
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH

`define RCR_ADDR          8'hEF
`define RCR_PAGE          8'h00
`define RCR_BIT_FLASH     6
`define RCR_BIT_CMP       5
`define RCR_BIT_SOFT      4
`define RCR_BIT_WDOG      3
`define RCR_BIT_CLK       2
`define RCR_BIT_SUPPLY    1
`define RCR_BIT_PIN       0
`define RCR_WDOG_DIV      4'hC
`define RCR_RST_FIRST     1'b1
`define RCR_RST_BIT       1'b0
`define RCR_RST_FLAGS     7'h00
`define RCR_RST_DATA      8'h00
`define RCR_CAUSE_POWER   3'h0
`define RCR_CAUSE_PIN     3'h1
`define RCR_CAUSE_CLK     3'h2
`define RCR_CAUSE_CMP     3'h3
`define RCR_CAUSE_WDOG    3'h4
`define RCR_CAUSE_SOFT    3'h5
`define RCR_CAUSE_FLASH   3'h6
`define RCR_CAUSE_SUPPLY  3'h7

`endif

// ==== bench/rcr_reset_cause_checker.sv ====
// Purpose: port checks of reset cause register
// Assumes: one clock, rst_n synchronous
// Notes:   bound by name
`timescale 1ns/1ns
module rcr_reset_cause_checker (
	// watched ports
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_page,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	input wire logic       watchdog_overflow,
	input wire logic       sys_reset_req,
	input wire logic       pin_reset_oe,
	input wire logic       clock_loss_detector_en,
	input wire logic       watchdog_function_en,
	input wire logic       watchdog_tick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ========
	// checks
	a_hit_decode: assert property (sfr_hit == (sfr_addr == 8'hEF && sfr_page == 8'h00))
		else $error("bad decode");
	a_top_zero: assert property (sfr_rdata[7] == 1'b0)
		else $error("bit 7 set");
	a_pin_free: assert property (pin_reset_oe == 1'b0)
		else $error("pin driven");
	a_wdog_on: assert property ($past(rst_n) |-> watchdog_function_en)
		else $error("watchdog off");
	a_tick_rate: assert property (watchdog_tick |-> ##12 watchdog_tick)
		else $error("tick period");
	a_wdog_req: assert property (watchdog_overflow |=> sys_reset_req)
		else $error("no watchdog reset");
	a_soft_req: assert property (sfr_wr && sfr_hit && sfr_wdata[4] |-> ##[1:3] sys_reset_req)
		else $error("no soft reset");
	a_clk_enable: assert property (sfr_wr && sfr_hit |=> clock_loss_detector_en == $past(sfr_wdata[2]))
		else $error("detector enable");
	a_rd_idle: assert property (!(sfr_rd && sfr_hit) |=> sfr_rdata == 8'h00)
		else $error("read data not idle");
	a_tick_gap: assert property (watchdog_tick |=> (!watchdog_tick) [*8])
		else $error("tick too early");
	cover property (sfr_wr && sfr_hit);
	cover property (watchdog_tick);
	cover property ($rose(sys_reset_req));
	cover property (sfr_wr && !sfr_hit);
endmodule // rcr_reset_cause_checker

bind rcr_reset_cause rcr_reset_cause_checker i_chk (.*);

// ==== bench/rcr_reset_cause_bench.sv ====
// Purpose: self-checking bench of reset cause register
// Assumes: sources idle between tests
// Notes:   rows of reset causes, then reset sources
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, a); end end
module rcr_reset_cause_bench;
	logic       clk_sys = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 1;
	logic       cmp_out = 1, clock_missing = 0, supply_low = 0;
	logic       watchdog_overflow = 0, flash_fault = 0;
	logic [2:0] reset_cause = 0;
	logic [7:0] sfr_addr = 8'hEF, sfr_page = 8'h00, sfr_wdata = 0;
	wire  [7:0] sfr_rdata;
	wire        sfr_hit, sys_reset_req, pin_reset_oe;
	wire        clock_loss_detector_en, watchdog_function_en, watchdog_tick;
	int         checks = 0, miscompares = 0, ticks = 0;
	logic [10:0] rows [8] = '{{3'h0,8'h02}, {3'h1,8'h01}, {3'h2,8'h04}, {3'h3,8'h20},
		{3'h4,8'h08}, {3'h5,8'h10}, {3'h6,8'h40}, {3'h7,8'h02}};
	logic [14:0] srcs [7] = '{{8'h20,5'h00,2'h1}, {8'h04,5'h18,2'h1}, {8'h02,5'h14,2'h1},
		{8'h00,5'h12,2'h1}, {8'h00,5'h11,2'h1}, {8'h10,5'h10,2'h2}, {8'h00,5'h0C,2'h0}};
	rcr_reset_cause i_dut (.*);
	always #50 clk_sys = ~clk_sys;
	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task rst(input [2:0] c);
		@(posedge clk_sys);
		reset_cause <= c;
		rst_n <= 0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1;
		repeat (2) @(posedge clk_sys);
	endtask
	task wr(input [7:0] d);
		sfr_wdata <= d;
		sfr_wr <= 1;
		@(posedge clk_sys);
		sfr_wr <= 0;
		@(posedge clk_sys);
	endtask
	initial begin
		#100000;
		miscompares++;
		stop_test;
	end
	initial begin
		foreach (rows[i]) begin
			rst(rows[i][10:8]);
			@(negedge clk_sys);
			`CHK("flags", rows[i][7:0], sfr_rdata)
			$display("cause %0d done", i);
		end
		foreach (srcs[i]) begin
			rst(3'h1);
			wr(srcs[i][14:7]);
			{cmp_out, clock_missing, supply_low, watchdog_overflow, flash_fault} <= srcs[i][6:2];
			@(negedge clk_sys);
			`CHK("req soft", srcs[i][1], sys_reset_req)
			@(negedge clk_sys);
			`CHK("req", srcs[i][0], sys_reset_req)
			@(posedge clk_sys);
			{cmp_out, clock_missing, supply_low, watchdog_overflow, flash_fault} <= 5'h10;
			$display("source %0d done", i);
		end
		rst(3'h1);
		wr(8'hC4);
		@(negedge clk_sys);
		`CHK("ro", 8'h01, sfr_rdata)
		`CHK("cld on", 1'b1, clock_loss_detector_en)
		`CHK("wdog", 1'b1, watchdog_function_en)
		@(posedge clk_sys);
		sfr_page <= 8'h01;
		wr(8'h00);
		@(negedge clk_sys);
		`CHK("page", 8'h00, sfr_rdata)
		`CHK("cld keep", 1'b1, clock_loss_detector_en)
		@(posedge clk_sys);
		sfr_page <= 8'h00;
		wr(8'h00);
		@(negedge clk_sys);
		`CHK("cld off", 1'b0, clock_loss_detector_en)
		@(posedge clk_sys);
		sfr_addr <= 8'hEE;
		wr(8'h04);
		@(negedge clk_sys);
		`CHK("addr rd", 8'h00, sfr_rdata)
		`CHK("addr wr", 1'b0, clock_loss_detector_en)
		`CHK("hit off", 1'b0, sfr_hit)
		@(posedge clk_sys);
		sfr_addr <= 8'hEF;
		sfr_rd <= 0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("rd idle", 8'h00, sfr_rdata)
		`CHK("hit on", 1'b1, sfr_hit)
		@(posedge clk_sys);
		sfr_rd <= 1;
		repeat (24) begin
			@(negedge clk_sys);
			ticks += watchdog_tick;
		end
		`CHK("ticks", 2, ticks)
		`CHK("rd back", 8'h01, sfr_rdata)
		`CHK("pin", 1'b0, pin_reset_oe)
		$display("access done");
		stop_test;
	end
endmodule // rcr_reset_cause_bench
